// ===== rtl/lfe_pkg.sv
/*
 * Shared constants, encodings and helpers for the lamp fault and enable
 * control block. Assumes a 20 MHz system clock and a free-running
 * inverter-side link clock near 48 ns.
 */
// Summary of operation
// - strap level selects one of two bus addresses
// - duty mode: brightness equals measured input duty
// - saving mode: brightness scaled by measured duty
// - both modes gate output with duty input
// - overcurrent latches summary and overcurrent status bits
// - only lamp-on write to control clears faults
// - any fault bit clears the lamp-control bit
// - status bit 3 reports lamp off without pulses
// - no activity before delay trip: open-lamp fault
// - open-lamp fault drops the inverter enable
// - delay latch cleared at reset and enable rise
package lfe_pkg;

    // command codes of the register map
    localparam logic [7:0] CMD_BRIGHT = 8'h00;
    localparam logic [7:0] CMD_CTRL   = 8'h01;
    localparam logic [7:0] CMD_STAT   = 8'h02;
    localparam logic [7:0] CMD_MODE   = 8'h03;

    // field positions
    localparam int CTRL_LAMP  = 0;
    localparam int STAT_FAULT = 0;
    localparam int STAT_OVC   = 2;
    localparam int STAT_OFF   = 3;

    // values after reset
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] BRIGHT_RST = 8'h00;

    // lamp activity hold time, from the detector capacitor decay
    localparam int LINK_CLK_NS   = 48;
    localparam int LAMP_HOLD_US  = 10000;
    localparam int LAMP_HOLD_CYC = (LAMP_HOLD_US * 1000) / LINK_CLK_NS;

    // duty measurement: samples per window and clocks per sample
    localparam logic [7:0] DUTY_WIN = 8'hFF;
    localparam int DUTY_DIV_DEF     = 64;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_CMD  = 3'b010,
        PH_WDAT = 3'b011,
        PH_RDAT = 3'b100,
        PH_SKIP = 3'b101
    } lfe_phase_type;

    typedef enum logic [1:0] {
        MODE_BUS  = 2'b00,
        MODE_DUTY = 2'b01,
        MODE_SAVE = 2'b10
    } lfe_mode_type;

    // a * b / 255, exact at both ends of the duty range
    function automatic logic [7:0] lfe_scale(input logic [7:0] a, input logic [7:0] b);
        logic [15:0] p;
        p = ({8'h00, a} * {8'h00, b}) + {8'h00, a};
        return p[15:8];
    endfunction

endpackage

// ===== rtl/lfe_lamp_link.sv
/*
 * Inverter-side logic on the link clock: lamp activity hold timer,
 * fault-delay latch and open-lamp detection. Assumes the link clock
 * runs freely and that the enable arrives from another clock domain.
 */
`timescale 1ns/1ns
module lfe_lamp_link #(
    parameter int HOLD_CYC = lfe_pkg::LAMP_HOLD_CYC
) (
    input  wire logic link_clk,            // inverter-side clock
    input  wire logic rst,                 // async reset, active high
    input  wire logic lamp_activity_input, // lamp pulses, asynchronous
    input  wire logic fault_delay_input,   // delay comparator, asynchronous
    input  wire logic enable_level,        // inverter enable, system domain
    output logic      lamp_on,             // lamp seen active, level
    output logic      open_toggle          // flips once per open-lamp fault
);
    import lfe_pkg::*;

    localparam int HW = $clog2(HOLD_CYC + 1);

    typedef struct packed {
        logic [1:0]    act_m;
        logic [1:0]    fd_m;
        logic [1:0]    en_m;
        logic          en_p;
        logic [HW-1:0] hold;
        logic          on;
        logic          fd_lat;
        logic          seen;
        logic          opn;
    } lfe_link_state_type;

    lfe_link_state_type s;
    lfe_link_state_type n;
    logic               en_rise;
    logic               fd_s;

    // edge of the crossed enable, second stage only
    assign en_rise = s.en_m[1] & ~s.en_p;
    assign fd_s    = s.fd_m[1];

    // next state
    always_comb begin
        n       = s;
        n.act_m = {s.act_m[0], lamp_activity_input};
        n.fd_m  = {s.fd_m[0], fault_delay_input};
        n.en_m  = {s.en_m[0], enable_level};
        n.en_p  = s.en_m[1];
        // each pulse recharges the hold, like the detector capacitor
        if (s.act_m[1]) begin
            n.hold = HW'(HOLD_CYC);
        end else if (s.hold != '0) begin
            n.hold = s.hold - 1'b1;
        end
        n.on = (n.hold != '0);
        if (en_rise) begin
            n.fd_lat = 1'b0;
            n.seen   = 1'b0;
        end else begin
            if (fd_s) begin
                n.fd_lat = 1'b1;
            end
            if (s.on) begin
                n.seen = 1'b1;
            end
            // only the first trip after an enable counts
            if (s.en_m[1] && fd_s && !s.fd_lat && !s.seen && !s.on) begin
                n.opn = ~s.opn;
            end
        end
    end

    // state register
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign lamp_on     = s.on;
    assign open_toggle = s.opn;

    AST_FD_CLEAR: assert property (@(posedge link_clk) disable iff (rst)
        en_rise |=> !s.fd_lat && !s.seen)
        else $error("delay latch not cleared on enable rise");

endmodule // lfe_lamp_link

// ===== rtl/lfe_top.sv
/*
 * Lamp fault and enable control: bus slave with write byte and read
 * byte, fault latching, inverter enable and duty-driven brightness.
 * Assumes a 20 MHz clock, an open-drain data line resolved outside,
 * and a free-running inverter-side link clock.
 */
`timescale 1ns/1ns
module lfe_top #(
    parameter logic [6:0] ADDR_LO  = 7'h2C,                  // strap low address
    parameter logic [6:0] ADDR_HI  = 7'h2D,                  // strap high address
    parameter int         DUTY_DIV = lfe_pkg::DUTY_DIV_DEF,  // clocks per sample
    parameter int         HOLD_CYC = lfe_pkg::LAMP_HOLD_CYC  // lamp hold, link clocks
) (
    input  wire logic  clock,               // 20 MHz system clock
    input  wire logic  rst,                 // async reset, active high
    input  wire logic  link_clk,            // inverter-side clock
    input  wire logic  scl_in,              // bus clock pin
    input  wire logic  sda_in,              // bus data pin level
    output logic       sda_out,             // bus data drive value
    output logic       sda_oe,              // high while pulling data low
    input  wire logic  address_strap,       // address select strap
    input  wire logic  system_duty_input,   // system duty-cycle signal
    input  wire logic  overcurrent_input,   // overcurrent comparator
    input  wire logic  lamp_activity_input, // lamp activity pulses
    input  wire logic  fault_delay_input,   // fault-delay comparator
    output logic [7:0] brightness_level,    // brightness setting
    output logic       brightness_output,   // on/off gate of brightness
    output logic       inverter_enable      // enable to the inverter
);
    import lfe_pkg::*;

    typedef struct packed {
        logic [1:0]    scl_m;
        logic          scl_p;
        logic [1:0]    sda_m;
        logic          sda_p;
        logic [1:0]    strap_m;
        logic [1:0]    duty_m;
        logic [1:0]    ovc_m;
        logic [1:0]    lamp_m;
        logic [1:0]    opn_m;
        logic          opn_p;
        lfe_phase_type ph;
        logic [3:0]    cnt;
        logic          arm;
        logic [7:0]    sh;
        logic [7:0]    cmd;
        logic [7:0]    tx;
        logic          oe;
        logic [7:0]    ctrl;
        logic [7:0]    bright;
        lfe_mode_type  mode;
        logic          flt_f;
        logic          ovc_f;
        logic [15:0]   div;
        logic [7:0]    smp;
        logic [7:0]    hi;
        logic [7:0]    duty;
        logic [7:0]    level;
        logic          gate;
    } lfe_top_state_type;

    lfe_top_state_type s;
    lfe_top_state_type n;

    logic       scl_s;
    logic       sda_s;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [6:0] cur_addr;
    logic       duty_s;
    logic       ovc_s;
    logic       lamp_s;
    logic       opn_ev;
    logic       wr;
    logic       wr_lamp1;
    logic       addr_hit;
    logic       rd_stat;
    logic       lamp_on_link;
    logic       open_toggle;

    // register read decode; unmapped commands read as zero
    function automatic logic [7:0] rd_mux(input logic [7:0] c,
                                          input lfe_top_state_type st);
        logic [7:0] r;
        r = 8'h00;
        if (c == CMD_BRIGHT) begin
            r = st.bright;
        end else if (c == CMD_CTRL) begin
            r = st.ctrl;
        end else if (c == CMD_STAT) begin
            r[STAT_FAULT] = st.flt_f;
            r[STAT_OVC]   = st.ovc_f;
            r[STAT_OFF]   = ~st.lamp_m[1];
        end else if (c == CMD_MODE) begin
            r[1:0] = st.mode;
        end
        return r;
    endfunction

    // inverter-side timers and the open-lamp detector
    lfe_lamp_link #(
        .HOLD_CYC (HOLD_CYC)
    ) u_link (
        .link_clk            (link_clk),
        .rst                 (rst),
        .lamp_activity_input (lamp_activity_input),
        .fault_delay_input   (fault_delay_input),
        .enable_level        (s.ctrl[CTRL_LAMP]),
        .lamp_on             (lamp_on_link),
        .open_toggle         (open_toggle)
    );

    // synchronised levels; first stages feed nothing but the second
    assign scl_s  = s.scl_m[1];
    assign sda_s  = s.sda_m[1];
    assign duty_s = s.duty_m[1];
    assign ovc_s  = s.ovc_m[1];
    assign lamp_s = s.lamp_m[1];
    assign opn_ev = s.opn_m[1] ^ s.opn_p;

    // bus events, one cycle each
    assign rise  = scl_s & ~s.scl_p;
    assign fall  = ~scl_s & s.scl_p;
    assign start = scl_s & s.scl_p & s.sda_p & ~sda_s;
    assign stop  = scl_s & s.scl_p & ~s.sda_p & sda_s;

    assign cur_addr = s.strap_m[1] ? ADDR_HI : ADDR_LO;

    // a data byte is taken at the falling edge that ends its eighth bit
    assign wr       = fall && (s.cnt == 4'h7) && (s.ph == PH_WDAT);
    assign wr_lamp1 = wr && (s.cmd == CMD_CTRL) && s.sh[CTRL_LAMP];
    assign addr_hit = fall && (s.cnt == 4'h7) && (s.ph == PH_ADDR)
                      && (s.sh[7:1] == cur_addr);
    assign rd_stat  = fall && (s.cnt == 4'h8) && (s.ph == PH_ADDR)
                      && s.sh[0] && (s.cmd == CMD_STAT);

    // next state
    always_comb begin
        n         = s;
        n.scl_m   = {s.scl_m[0], scl_in};
        n.sda_m   = {s.sda_m[0], sda_in};
        n.strap_m = {s.strap_m[0], address_strap};
        n.duty_m  = {s.duty_m[0], system_duty_input};
        n.ovc_m   = {s.ovc_m[0], overcurrent_input};
        n.lamp_m  = {s.lamp_m[0], lamp_on_link};
        n.opn_m   = {s.opn_m[0], open_toggle};
        n.scl_p   = scl_s;
        n.sda_p   = sda_s;
        n.opn_p   = s.opn_m[1];

        // bit engine; a repeated start keeps the command byte
        if (start) begin
            n.ph  = PH_ADDR;
            n.cnt = 4'h0;
            n.arm = 1'b1;
            n.oe  = 1'b0;
        end else if (stop) begin
            n.ph = PH_IDLE;
            n.oe = 1'b0;
        end else if (s.ph != PH_IDLE) begin
            if (rise) begin
                if (s.cnt < 4'h8) begin
                    n.sh = {s.sh[6:0], sda_s};
                end else if (s.ph == PH_RDAT && sda_s) begin
                    n.ph = PH_SKIP; // host refused further data
                end
            end
            if (fall && s.arm) begin
                // the fall that closes a start carries no bit; counting it shifts every byte
                n.arm = 1'b0;
            end else if (fall) begin
                if (s.cnt < 4'h7) begin
                    n.cnt = s.cnt + 4'h1;
                    if (s.ph == PH_RDAT) begin
                        n.tx = {s.tx[6:0], 1'b1};
                        n.oe = ~n.tx[7];
                    end
                end else if (s.cnt == 4'h7) begin
                    n.cnt = 4'h8;
                    n.oe  = 1'b0;
                    case (s.ph)
                        PH_ADDR: begin
                            if (addr_hit) begin
                                n.oe = 1'b1;
                            end else begin
                                n.ph = PH_SKIP;
                            end
                        end
                        PH_CMD: begin
                            n.cmd = s.sh;
                            n.oe  = 1'b1;
                        end
                        PH_WDAT: begin
                            n.oe = 1'b1;
                        end
                        default: begin
                            n.oe = 1'b0;
                        end
                    endcase
                end else begin
                    n.cnt = 4'h0;
                    n.oe  = 1'b0;
                    case (s.ph)
                        PH_ADDR: begin
                            if (s.sh[0]) begin
                                n.ph = PH_RDAT;
                                n.tx = rd_mux(s.cmd, s);
                                n.oe = ~n.tx[7];
                            end else begin
                                n.ph = PH_CMD;
                            end
                        end
                        PH_CMD: begin
                            n.ph = PH_WDAT;
                        end
                        default: begin
                            // one byte per transfer; extra bytes are ignored
                            n.ph = PH_SKIP;
                        end
                    endcase
                end
            end
        end

        // register writes
        if (wr) begin
            if (s.cmd == CMD_CTRL) begin
                n.ctrl = s.sh;
                if (s.sh[CTRL_LAMP]) begin
                    n.flt_f = 1'b0;
                    n.ovc_f = 1'b0;
                end
            end else if (s.cmd == CMD_BRIGHT) begin
                n.bright = s.sh;
            end else if (s.cmd == CMD_MODE) begin
                n.mode = lfe_mode_type'(s.sh[1:0]);
            end
        end

        // fault setting comes after the clear, so a new event wins
        if (ovc_s) begin
            n.flt_f = 1'b1;
            n.ovc_f = 1'b1;
        end
        if (opn_ev) begin
            n.flt_f = 1'b1;
        end
        if (n.flt_f || n.ovc_f) begin
            n.ctrl[CTRL_LAMP] = 1'b0;
        end

        // duty measurement over a fixed window of samples
        n.div = s.div + 16'h0001;
        if (s.div == 16'(DUTY_DIV - 1)) begin
            n.div = 16'h0000;
            n.hi  = s.hi + {7'h00, duty_s};
            n.smp = s.smp + 8'h01;
            if (s.smp == DUTY_WIN - 8'h01) begin
                n.duty = s.hi + {7'h00, duty_s};
                n.hi   = 8'h00;
                n.smp  = 8'h00;
            end
        end

        // brightness setting and gate per mode
        case (s.mode)
            MODE_DUTY: begin
                n.level = s.duty;
                n.gate  = duty_s;
            end
            MODE_SAVE: begin
                n.level = lfe_scale(s.bright, s.duty);
                n.gate  = duty_s;
            end
            default: begin
                n.level = s.bright;
                n.gate  = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // outputs; the data line is open-drain, only ever pulled low
    assign sda_out           = 1'b0;
    assign sda_oe            = s.oe;
    assign brightness_level  = s.level;
    assign brightness_output = s.gate;
    assign inverter_enable   = s.ctrl[CTRL_LAMP];

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_open_evt;
        opn_ev ##1 s.flt_f;
    endsequence

    sequence s_addr_ack;
        addr_hit ##1 (s.oe && s.ph == PH_ADDR);
    endsequence

    AST_ADDR_ACK: assert property (addr_hit |-> s_addr_ack)
        else $error("matching address not acknowledged");

    AST_DUTY_LEVEL: assert property ((s.mode == MODE_DUTY) |=>
        brightness_level == $past(s.duty))
        else $error("duty mode level differs from measured duty");

    AST_SAVE_LEVEL: assert property ((s.mode == MODE_SAVE) |=>
        brightness_level == lfe_scale($past(s.bright), $past(s.duty)))
        else $error("saving mode level not scaled by duty");

    AST_GATE: assert property ((s.mode == MODE_DUTY || s.mode == MODE_SAVE)
        |=> brightness_output == $past(duty_s))
        else $error("brightness gate does not follow duty input");

    AST_OVC_LATCH: assert property (ovc_s |=> s.ovc_f && s.flt_f)
        else $error("overcurrent not latched");

    AST_CLR_ONLY: assert property ($fell(s.ovc_f) |-> $past(wr_lamp1))
        else $error("overcurrent bit cleared without lamp write");

    AST_FAULT_OFF: assert property ((s.flt_f || s.ovc_f) && !wr_lamp1
        |=> !inverter_enable)
        else $error("enable stays high with a fault latched");

    AST_LAMP_OFF: assert property (rd_stat |=> s.tx[STAT_OFF] == !$past(lamp_s))
        else $error("lamp-off status bit wrong");

    AST_OPEN_FLT: assert property (opn_ev |=> s.flt_f)
        else $error("open lamp not recorded");

    AST_OPEN_EN: assert property (s_open_evt |-> !inverter_enable)
        else $error("enable high after open lamp");

    AST_EN_FOLLOW: assert property (wr && s.cmd == CMD_CTRL && !ovc_s && !opn_ev
        |=> inverter_enable == $past(s.sh[CTRL_LAMP]) ##1 1'b1)
        else $error("enable does not follow written bit");

endmodule // lfe_top

// ===== bench/lfe_inv_model.sv
/*
 * Stand-in for the inverter controller: lamp activity pulses and the
 * timeout ramp feeding the fault-delay comparator.
 * Assumes the enable comes from the device and link_clk runs freely.
 */
`timescale 1ns/1ns
module lfe_inv_model #(
    parameter int RAMP = 20 // link clocks until the timeout trips
) (
    input  wire logic link_clk,      // inverter-side clock
    input  wire logic enable,        // enable from the device
    input  wire logic pulse_on,      // bench: lamp strikes when enabled
    output logic      lamp_activity, // activity pulses
    output logic      delay_trip     // timeout comparator output
);
    logic [7:0] ramp_reg;
    logic       tog_reg;

    initial begin
        ramp_reg = 8'h00;
        tog_reg  = 1'b0;
    end

    // ramp only runs while enabled, so a dropped enable rearms it
    always @(posedge link_clk) begin
        tog_reg  <= ~tog_reg;
        ramp_reg <= !enable ? 8'h00 : (ramp_reg < RAMP ? ramp_reg + 8'h01 : ramp_reg);
    end

    // pulses, not a level: the device must keep its own hold time
    assign lamp_activity = enable & pulse_on & tog_reg;
    assign delay_trip    = (ramp_reg >= RAMP);
endmodule // lfe_inv_model

// ===== bench/tb.sv
/*
 * Self-checking bench for lfe_top: bit-banged bus host, fault and
 * lamp scenarios, duty-driven brightness.
 * Assumes the data line has a pull-up, resolved here from all drivers.
 */
`timescale 1ns/1ns
module tb;
    import lfe_pkg::*;

    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       link_clk = 1'b0;
    logic       scl = 1'b1;
    logic       tb_low = 1'b0;
    logic       strap = 1'b0;
    logic       duty_in = 1'b0;
    logic       ovc = 1'b0;
    logic       pulse_on = 1'b1;
    logic       act, trip, sda_out, sda_oe, bout, inv_en;
    logic [7:0] level, rd;
    logic       ack;
    int         err_count = 0;
    int         checks = 0;
    int         cycles = 0;
    wire        sda_line = (tb_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1; // pull-up

    always #25 clock = ~clock;
    always #24 link_clk = ~link_clk;

    lfe_top #(.DUTY_DIV(1), .HOLD_CYC(50)) i_dut (
        .clock(clock), .rst(rst), .link_clk(link_clk), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap(strap), .system_duty_input(duty_in),
        .overcurrent_input(ovc), .lamp_activity_input(act),
        .fault_delay_input(trip), .brightness_level(level),
        .brightness_output(bout), .inverter_enable(inv_en));

    lfe_inv_model i_inv (.link_clk(link_clk), .enable(inv_en), .pulse_on(pulse_on),
        .lamp_activity(act), .delay_trip(trip));

    task automatic final_report;
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard, about a tenth above the planned traffic
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            err_count++;
            final_report;
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic clk_wait(input int n);
        repeat (n) @(posedge clock);
    endtask

    // quarter of a 100 kHz bus period, so every phase is 50 clocks
    task automatic bit_xfer(input logic b, output logic r);
        tb_low <= !b;
        clk_wait(50);
        scl <= 1'b1;
        clk_wait(50);
        r = sda_line;
        clk_wait(50);
        scl <= 1'b0;
        clk_wait(50);
    endtask

    // also serves as repeated start
    task automatic bus_start;
        tb_low <= 1'b0;
        clk_wait(50);
        scl <= 1'b1;
        clk_wait(50);
        tb_low <= 1'b1;
        clk_wait(50);
        scl <= 1'b0;
        clk_wait(50);
    endtask

    task automatic bus_stop;
        tb_low <= 1'b1;
        clk_wait(50);
        scl <= 1'b1;
        clk_wait(50);
        tb_low <= 1'b0;
        clk_wait(50);
    endtask

    // byte out MSB first, bits seen on the line back, then the ack slot
    task automatic byte_xfer(input logic [7:0] d, output logic [7:0] r, output logic a);
        logic nb;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r[i]);
        end
        bit_xfer(1'b1, nb);
        a = !nb;
    endtask

    task automatic probe(input logic [6:0] addr, input logic exp);
        bus_start;
        byte_xfer({addr, 1'b0}, rd, ack);
        bus_stop;
        check({7'h00, ack}, {7'h00, exp});
    endtask

    task automatic reg_write(input logic [7:0] cmd, input logic [7:0] data);
        bus_start;
        byte_xfer({7'h2C, 1'b0}, rd, ack);
        byte_xfer(cmd, rd, ack);
        byte_xfer(data, rd, ack);
        bus_stop;
        check({7'h00, ack}, 8'h01);
    endtask

    task automatic reg_read(input logic [7:0] cmd, output logic [7:0] data);
        bus_start;
        byte_xfer({7'h2C, 1'b0}, rd, ack);
        byte_xfer(cmd, rd, ack);
        bus_start;
        byte_xfer({7'h2C, 1'b1}, rd, ack);
        byte_xfer(8'hFF, data, ack);
        bus_stop;
    endtask

    initial begin
        clk_wait(4);
        rst <= 1'b0;
        clk_wait(8);
        check({7'h00, inv_en}, 8'h00);
        // strap picks one of two addresses
        probe(7'h2C, 1'b1);
        probe(7'h2D, 1'b0);
        strap <= 1'b1;
        clk_wait(10);
        probe(7'h2D, 1'b1);
        strap <= 1'b0;
        clk_wait(10);
        // lamp on, then an overcurrent trip
        reg_write(CMD_CTRL, 8'h01);
        clk_wait(5);
        check({7'h00, inv_en}, 8'h01);
        ovc <= 1'b1;
        clk_wait(8);
        ovc <= 1'b0;
        clk_wait(4);
        check({7'h00, inv_en}, 8'h00);
        reg_read(CMD_STAT, rd);
        check(rd, 8'h0D);
        // clearing the lamp bit must not clear faults
        reg_write(CMD_CTRL, 8'h00);
        reg_read(CMD_STAT, rd);
        check(rd, 8'h0D);
        // lamp never strikes before the timeout
        pulse_on <= 1'b0;
        reg_write(CMD_CTRL, 8'h01);
        clk_wait(100);
        check({7'h00, inv_en}, 8'h00);
        reg_read(CMD_STAT, rd);
        check(rd, 8'h09);
        // lamp strikes first: timeout trips later without a fault
        pulse_on <= 1'b1;
        reg_write(CMD_CTRL, 8'h01);
        clk_wait(100);
        check({7'h00, inv_en}, 8'h01);
        reg_read(CMD_STAT, rd);
        check(rd, 8'h00);
        // duty mode: full duty, then gating off
        duty_in <= 1'b1;
        reg_write(CMD_MODE, 8'h01);
        clk_wait(600);
        check(level, 8'hFF);
        check({7'h00, bout}, 8'h01);
        duty_in <= 1'b0;
        clk_wait(6);
        check({7'h00, bout}, 8'h00);
        // saving mode: setting scaled by measured duty
        reg_write(CMD_BRIGHT, 8'h80);
        reg_write(CMD_MODE, 8'h02);
        duty_in <= 1'b1;
        clk_wait(600);
        check(level, 8'h80);
        check({7'h00, bout}, 8'h01);
        duty_in <= 1'b0;
        clk_wait(600);
        check(level, 8'h00);
        check({7'h00, bout}, 8'h00);
        // back to bus mode: stored setting, gate held on
        reg_write(CMD_MODE, 8'h00);
        clk_wait(4);
        check(level, 8'h80);
        check({7'h00, bout}, 8'h01);
        final_report;
    end
endmodule // tb
